// *** verilog/forr_pkg.sv ***
// package: register map, reset values and variable selectors of the observation bank
package forr_pkg;
    localparam int FORR_NUM_OBS = 7;
    localparam int FORR_DATA_W = 32;
    localparam int FORR_ADDR_W = 16;
    localparam int FORR_IDX_W = 11;

    // printed offsets are word indices; byte address is four times the index
    localparam logic [FORR_IDX_W-1:0] FORR_IDX_COS = 11'h4BC;
    localparam logic [FORR_IDX_W-1:0] FORR_IDX_ALPHA_CUR = 11'h4D4;
    localparam logic [FORR_IDX_W-1:0] FORR_IDX_BETA_CUR = 11'h4D6;
    localparam logic [FORR_IDX_W-1:0] FORR_IDX_ALPHA_VOLT = 11'h4D8;
    localparam logic [FORR_IDX_W-1:0] FORR_IDX_BETA_VOLT = 11'h4DA;
    localparam logic [FORR_IDX_W-1:0] FORR_IDX_DIRECT_CUR = 11'h4E4;
    localparam logic [FORR_IDX_W-1:0] FORR_IDX_QUAD_CUR = 11'h4E6;
    localparam logic [FORR_IDX_W-1:0] FORR_IDX_CTRL = 11'h4F0;
    localparam logic [FORR_IDX_W-1:0] FORR_IDX_STAT = 11'h4F2;

    localparam logic [FORR_ADDR_W-1:0] FORR_ADDR_COS = {3'h0, FORR_IDX_COS, 2'h0};
    localparam logic [FORR_ADDR_W-1:0] FORR_ADDR_ALPHA_CUR = {3'h0, FORR_IDX_ALPHA_CUR, 2'h0};
    localparam logic [FORR_ADDR_W-1:0] FORR_ADDR_BETA_CUR = {3'h0, FORR_IDX_BETA_CUR, 2'h0};
    localparam logic [FORR_ADDR_W-1:0] FORR_ADDR_ALPHA_VOLT = {3'h0, FORR_IDX_ALPHA_VOLT, 2'h0};
    localparam logic [FORR_ADDR_W-1:0] FORR_ADDR_BETA_VOLT = {3'h0, FORR_IDX_BETA_VOLT, 2'h0};
    localparam logic [FORR_ADDR_W-1:0] FORR_ADDR_DIRECT_CUR = {3'h0, FORR_IDX_DIRECT_CUR, 2'h0};
    localparam logic [FORR_ADDR_W-1:0] FORR_ADDR_QUAD_CUR = {3'h0, FORR_IDX_QUAD_CUR, 2'h0};
    localparam logic [FORR_ADDR_W-1:0] FORR_ADDR_CTRL = {3'h0, FORR_IDX_CTRL, 2'h0};
    localparam logic [FORR_ADDR_W-1:0] FORR_ADDR_STAT = {3'h0, FORR_IDX_STAT, 2'h0};

    // observation addresses in selector order
    localparam logic [FORR_ADDR_W-1:0] FORR_OBS_ADDR [FORR_NUM_OBS] = '{
        FORR_ADDR_COS, FORR_ADDR_ALPHA_CUR, FORR_ADDR_BETA_CUR, FORR_ADDR_ALPHA_VOLT,
        FORR_ADDR_BETA_VOLT, FORR_ADDR_DIRECT_CUR, FORR_ADDR_QUAD_CUR};

    localparam logic [FORR_DATA_W-1:0] FORR_OBS_RESET = 32'h0000_0000;
    localparam logic [FORR_DATA_W-1:0] FORR_RDATA_ZERO = 32'h0000_0000;
    localparam logic FORR_FREEZE_RESET = 1'b0;

    // control and status field positions
    localparam int FORR_CTRL_FREEZE_BIT = 0;
    localparam int FORR_STAT_LOADED_LSB = 0;
    localparam int FORR_STAT_FREEZE_BIT = 8;
    localparam int FORR_STAT_PENDING_LSB = 16;

    // selects which variable the control algorithm is writing
    typedef enum logic [2:0] {
        FORR_VAR_COS,
        FORR_VAR_ALPHA_CUR,
        FORR_VAR_BETA_CUR,
        FORR_VAR_ALPHA_VOLT,
        FORR_VAR_BETA_VOLT,
        FORR_VAR_DIRECT_CUR,
        FORR_VAR_QUAD_CUR
    } forr_var_t;
endpackage

// *** verilog/forr_obs_reg.sv ***
// one observation register with freeze shadow
`timescale 1ns/1ns
module forr_obs_reg (
    input wire logic i_ref_clk, // core clock
    input wire logic i_resetn, // sync reset, active low
    input wire logic i_update, // algorithm writes this variable
    input wire logic [forr_pkg::FORR_DATA_W-1:0] i_data, // new value
    input wire logic i_freeze, // hold visible value
    output logic [forr_pkg::FORR_DATA_W-1:0] o_value, // visible value
    output logic o_loaded, // written at least once since reset
    output logic o_pending // newer value waiting behind freeze
);
    import forr_pkg::*;

    logic [FORR_DATA_W-1:0] shadow;

    // latest value wins; held back while frozen so reads stay coherent
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_value <= FORR_OBS_RESET;
        end else if (i_update && !i_freeze) begin
            o_value <= i_data;
        end else if (!i_freeze && o_pending) begin
            o_value <= shadow;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            shadow <= FORR_OBS_RESET;
        end else if (i_update) begin
            shadow <= i_data;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_pending <= 1'b0;
        end else if (i_update && i_freeze) begin
            o_pending <= 1'b1;
        end else if (!i_freeze) begin
            o_pending <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_loaded <= 1'b0;
        end else if (i_update) begin
            o_loaded <= 1'b1;
        end
    end
endmodule

// *** verilog/forr_addr_decode.sv ***
// address decode of the observation bank
`timescale 1ns/1ns
module forr_addr_decode (
    input wire logic [forr_pkg::FORR_ADDR_W-1:0] i_paddr, // bus byte address
    output logic [forr_pkg::FORR_NUM_OBS-1:0] o_obs_hit, // one-hot observation hit
    output logic o_ctrl_hit, // control register
    output logic o_stat_hit, // status register
    output logic o_mapped // any register hit
);
    import forr_pkg::*;

    always_comb begin
        for (int k = 0; k < FORR_NUM_OBS; k++) begin
            o_obs_hit[k] = (i_paddr == FORR_OBS_ADDR[k]);
        end
        o_ctrl_hit = (i_paddr == FORR_ADDR_CTRL);
        o_stat_hit = (i_paddr == FORR_ADDR_STAT);
        o_mapped = (|o_obs_hit) || o_ctrl_hit || o_stat_hit;
    end
endmodule

// *** verilog/forr_regs.sv ***
// top: read-only observation register bank of the field-oriented controller, APB slave
//
// Operation
// - the commutation-angle cosine reads as a 32-bit value at index 0x4BC, scaled by 2^27.
// - the alpha-axis current reads at index 0x4D4, amperes being value / 2^27 * 1.25.
// - the beta-axis current reads at index 0x4D6, amperes being value / 2^27 * 1.25.
// - the alpha-axis voltage reads at index 0x4D8, volts being value / 2^27 * 60 / sqrt(3).
// - the beta-axis voltage reads at index 0x4DA, volts being value / 2^27 * 60 / sqrt(3).
// - the estimated direct-axis current reads at index 0x4E4, scaled like the other currents.
// - the estimated quadrature-axis current reads at index 0x4E6, scaled like the other currents.
// - after reset every observation register reads zero until the algorithm writes it.
`timescale 1ns/1ns
module forr_regs (
    input wire logic i_ref_clk, // 125 MHz core clock
    input wire logic i_resetn, // sync reset, active low
    input wire logic i_psel, // apb select
    input wire logic i_penable, // apb access phase
    input wire logic i_pwrite, // apb direction
    input wire logic [forr_pkg::FORR_ADDR_W-1:0] i_paddr, // apb byte address
    input wire logic [forr_pkg::FORR_DATA_W-1:0] i_pwdata, // apb write data
    input wire logic [3:0] i_pstrb, // apb byte strobes
    output logic [forr_pkg::FORR_DATA_W-1:0] o_prdata, // apb read data
    output logic o_pready, // apb ready
    output logic o_pslverr, // apb error, unmapped address
    input wire logic i_alg_wr, // algorithm update strobe
    input wire forr_pkg::forr_var_t i_alg_sel, // variable being updated
    input wire logic [forr_pkg::FORR_DATA_W-1:0] i_alg_data, // updated value
    output logic o_freeze // readback freeze state
);
    import forr_pkg::*;

    logic [FORR_NUM_OBS-1:0] obs_hit;
    logic ctrl_hit;
    logic stat_hit;
    logic mapped;
    logic [FORR_NUM_OBS-1:0] obs_update;
    logic [FORR_NUM_OBS-1:0] obs_loaded;
    logic [FORR_NUM_OBS-1:0] obs_pending;
    logic [FORR_DATA_W-1:0] obs_value [FORR_NUM_OBS];
    logic setup_phase;
    logic access_done;
    logic ctrl_write;
    logic [FORR_DATA_W-1:0] next_prdata;
    logic [FORR_DATA_W-1:0] status_word;

    forr_addr_decode u_decode (
        .i_paddr(i_paddr),
        .o_obs_hit(obs_hit),
        .o_ctrl_hit(ctrl_hit),
        .o_stat_hit(stat_hit),
        .o_mapped(mapped)
    );

    // only the algorithm port reaches the observation registers
    always_comb begin
        for (int k = 0; k < FORR_NUM_OBS; k++) begin
            obs_update[k] = i_alg_wr && (i_alg_sel == forr_var_t'(k));
        end
    end

    genvar g;
    generate
        for (g = 0; g < FORR_NUM_OBS; g++) begin : g_obs
            forr_obs_reg u_obs (
                .i_ref_clk(i_ref_clk),
                .i_resetn(i_resetn),
                .i_update(obs_update[g]),
                .i_data(i_alg_data),
                .i_freeze(o_freeze),
                .o_value(obs_value[g]),
                .o_loaded(obs_loaded[g]),
                .o_pending(obs_pending[g])
            );
        end
    endgenerate

    assign setup_phase = i_psel && !i_penable;
    assign access_done = i_psel && i_penable && o_pready;
    assign ctrl_write = access_done && i_pwrite && ctrl_hit && i_pstrb[0];

    always_comb begin
        status_word = FORR_RDATA_ZERO;
        status_word[FORR_STAT_LOADED_LSB +: FORR_NUM_OBS] = obs_loaded;
        status_word[FORR_STAT_FREEZE_BIT] = o_freeze;
        status_word[FORR_STAT_PENDING_LSB +: FORR_NUM_OBS] = obs_pending;
    end

    // read mux: one observation word per aligned address
    always_comb begin
        next_prdata = FORR_RDATA_ZERO;
        for (int k = 0; k < FORR_NUM_OBS; k++) begin
            if (obs_hit[k]) begin
                next_prdata = obs_value[k];
            end
        end
        if (ctrl_hit) begin
            next_prdata[FORR_CTRL_FREEZE_BIT] = o_freeze;
        end
        if (stat_hit) begin
            next_prdata = status_word;
        end
    end

    // zero wait states: ready rises in the access phase, data latched at setup
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_pready <= 1'b0;
        end else begin
            o_pready <= setup_phase;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_prdata <= FORR_RDATA_ZERO;
        end else if (setup_phase && !i_pwrite) begin
            o_prdata <= next_prdata;
        end
    end

    // writes to observation words are accepted without error and dropped
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_pslverr <= 1'b0;
        end else if (setup_phase) begin
            o_pslverr <= !mapped;
        end else begin
            o_pslverr <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_freeze <= FORR_FREEZE_RESET;
        end else if (ctrl_write) begin
            o_freeze <= i_pwdata[FORR_CTRL_FREEZE_BIT];
        end
    end

    // checks
    logic [FORR_DATA_W*FORR_NUM_OBS-1:0] obs_flat;
    logic bank_quiet;
    logic [FORR_DATA_W-1:0] last_quad;

    always_comb begin
        for (int k = 0; k < FORR_NUM_OBS; k++) begin
            obs_flat[k*FORR_DATA_W +: FORR_DATA_W] = obs_value[k];
        end
    end

    assign bank_quiet = !i_alg_wr && (o_freeze || !(|obs_pending));

    // latest quadrature word, kept apart from the register so release order can be checked
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            last_quad <= FORR_OBS_RESET;
        end else if (obs_update[6]) begin
            last_quad <= i_alg_data;
        end
    end

    sequence s_read_setup(logic [FORR_ADDR_W-1:0] addr);
        i_psel && !i_penable && !i_pwrite && (i_paddr == addr);
    endsequence

    sequence s_read_answer(logic [FORR_DATA_W-1:0] val);
        o_pready && !o_pslverr && (o_prdata == val);
    endsequence

    sequence s_host_write;
        i_psel && i_penable && o_pready && i_pwrite;
    endsequence

    property p_read_word(logic [FORR_ADDR_W-1:0] addr, logic [FORR_DATA_W-1:0] val);
        @(posedge i_ref_clk) disable iff (!i_resetn)
        s_read_setup(addr) |=> s_read_answer($past(val));
    endproperty

    cosine_read_a: assert property (p_read_word(FORR_ADDR_COS, obs_value[0]))
        else $error("cosine readback wrong");
    alpha_current_a: assert property (p_read_word(FORR_ADDR_ALPHA_CUR, obs_value[1]))
        else $error("alpha current readback wrong");
    beta_current_a: assert property (p_read_word(FORR_ADDR_BETA_CUR, obs_value[2]))
        else $error("beta current readback wrong");
    alpha_voltage_a: assert property (p_read_word(FORR_ADDR_ALPHA_VOLT, obs_value[3]))
        else $error("alpha voltage readback wrong");
    beta_voltage_a: assert property (p_read_word(FORR_ADDR_BETA_VOLT, obs_value[4]))
        else $error("beta voltage readback wrong");
    direct_current_a: assert property (p_read_word(FORR_ADDR_DIRECT_CUR, obs_value[5]))
        else $error("direct current readback wrong");
    quad_current_a: assert property (p_read_word(FORR_ADDR_QUAD_CUR, obs_value[6]))
        else $error("quadrature current readback wrong");

    reset_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        $rose(i_resetn) |-> (obs_flat == '0) && (obs_loaded == '0))
        else $error("observation bank not zero after reset");

    unloaded_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (!obs_loaded[0] && !obs_update[0]) |=> (obs_value[0] == FORR_OBS_RESET))
        else $error("cosine changed before first algorithm write");

    host_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (s_host_write and bank_quiet) |=> $stable(obs_flat))
        else $error("host write altered an observation register");

    alg_update_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (obs_update[6] && !o_freeze) |=> (obs_value[6] == $past(i_alg_data)))
        else $error("algorithm update of quadrature current lost");

    ready_pulse_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_psel && !i_penable) |=> o_pready ##1 !o_pready)
        else $error("ready not a single access-phase cycle");

    unmapped_err_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (setup_phase && !mapped) |=> (o_pready && o_pslverr))
        else $error("unmapped access not flagged");

    // control word, status word, the freeze shadow, algorithm updates and the bus handshake
    sequence s_ctrl_read;
        i_psel && !i_penable && !i_pwrite && ctrl_hit;
    endsequence

    sequence s_ctrl_write;
        i_psel && i_penable && o_pready && i_pwrite && ctrl_hit && i_pstrb[0];
    endsequence

    sequence s_masked_write;
        i_psel && i_penable && o_pready && i_pwrite && ctrl_hit && !i_pstrb[0];
    endsequence

    status_read_a: assert property (
        p_read_word(FORR_ADDR_STAT, status_word))
        else $error("status readback wrong");

    ctrl_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        s_ctrl_read
        |=> s_read_answer({{(FORR_DATA_W-1){1'b0}}, $past(o_freeze)}))
        else $error("control readback wrong");

    ctrl_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        s_ctrl_write
        |=> (o_freeze == $past(i_pwdata[FORR_CTRL_FREEZE_BIT])))
        else $error("freeze bit not written");

    strobe_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        s_masked_write
        |=> $stable(o_freeze))
        else $error("freeze changed without byte strobe");

    freeze_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        o_freeze
        |=> $stable(obs_flat))
        else $error("observation word moved while frozen");

    pending_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (o_freeze && (|obs_update))
        |=> (|obs_pending))
        else $error("update during freeze not held back");

    pending_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        !o_freeze
        |=> (obs_pending == '0))
        else $error("pending flag left after release");

    quad_release_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (!o_freeze && !obs_update[6])
        |=> (obs_value[6] == last_quad))
        else $error("quadrature current not the latest update");

    loaded_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        obs_update[0]
        |=> obs_loaded[0])
        else $error("loaded flag not set by update");

    cos_update_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (obs_update[0] && !o_freeze)
        |=> (obs_value[0] == $past(i_alg_data)))
        else $error("algorithm update of cosine lost");

    direct_update_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (obs_update[5] && !o_freeze)
        |=> (obs_value[5] == $past(i_alg_data)))
        else $error("algorithm update of direct current lost");

    prdata_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        !(setup_phase && !i_pwrite)
        |=> $stable(o_prdata))
        else $error("read data changed outside a read setup");

    idle_ready_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        !i_psel
        |=> !o_pready)
        else $error("ready without select");

    mapped_ok_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (setup_phase && mapped)
        |=> (o_pready && !o_pslverr))
        else $error("mapped access flagged as error");

    err_with_ready_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        o_pslverr
        |-> o_pready)
        else $error("error shown outside access phase");

    bus_reset_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        $rose(i_resetn)
        |-> (!o_freeze && !o_pready && !o_pslverr && (o_prdata == FORR_RDATA_ZERO)))
        else $error("bus outputs not cleared by reset");
endmodule

// *** bench/forr_regs_test.sv ***
// self-checking bench of the observation register bank over apb
`timescale 1ns/1ns
module forr_regs_test;
    import forr_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [FORR_ADDR_W-1:0] i_paddr = '0;
    logic [FORR_DATA_W-1:0] i_pwdata = '0;
    logic [3:0] i_pstrb = 4'hf;
    logic [FORR_DATA_W-1:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    logic i_alg_wr = 1'b0;
    forr_var_t i_alg_sel = forr_var_t'(3'h0);
    logic [FORR_DATA_W-1:0] i_alg_data = '0;
    logic o_freeze;
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic er;

    forr_regs i_forr_regs (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_alg_wr(i_alg_wr), .i_alg_sel(i_alg_sel), .i_alg_data(i_alg_data), .o_freeze(o_freeze));

    always #4 i_ref_clk = ~i_ref_clk;

    // distinct signed fixed-point pattern per variable
    function automatic logic [31:0] val(input int k, input logic [31:0] salt);
        val = (32'hC000_0001 + (k << 24)) ^ salt;
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_ref_clk);
        i_penable <= 1'b1;
        @(posedge i_ref_clk);
        while (o_pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge i_ref_clk);
        end
        if (n == 50) cmp1(1'b0, 1'b1, "pready never came");
        r = o_prdata;
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic read_chk(input logic [15:0] a, input logic [31:0] exp, input logic eexp);
        apb(1'b0, a, 32'h0000_0000, rd, er);
        if (!eexp) cmp32(rd, exp, "read data");
        cmp1(er, eexp, "slave error");
    endtask

    task automatic do_reset();
        @(posedge i_ref_clk);
        i_resetn <= 1'b0;
        repeat (6) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
    endtask

    task automatic alg_all(input logic [31:0] salt);
        for (int k = 0; k < FORR_NUM_OBS; k++) begin
            @(posedge i_ref_clk);
            i_alg_wr <= 1'b1;
            i_alg_sel <= forr_var_t'(k[2:0]);
            i_alg_data <= val(k, salt);
        end
        @(posedge i_ref_clk);
        i_alg_wr <= 1'b0;
    endtask

    always @(posedge i_ref_clk) begin
        cycles++;
        // whole run needs well under a thousand cycles
        if (cycles == 5000) begin
            error_cnt++;
            $display("mismatch at %0t: run did not finish", $time);
            results();
        end
    end

    initial begin
        repeat (6) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        for (int k = 0; k < FORR_NUM_OBS; k++) read_chk(FORR_OBS_ADDR[k], 32'h0000_0000, 1'b0);
        $display("test reset values done");
        alg_all(32'h0000_0000);
        read_chk(FORR_OBS_ADDR[0], val(0, 0), 1'b0);
        read_chk(FORR_OBS_ADDR[1], val(1, 0), 1'b0);
        read_chk(FORR_OBS_ADDR[2], val(2, 0), 1'b0);
        read_chk(FORR_OBS_ADDR[3], val(3, 0), 1'b0);
        read_chk(FORR_OBS_ADDR[4], val(4, 0), 1'b0);
        read_chk(FORR_OBS_ADDR[5], val(5, 0), 1'b0);
        read_chk(FORR_OBS_ADDR[6], val(6, 0), 1'b0);
        $display("test algorithm readback done");
        for (int k = 0; k < FORR_NUM_OBS; k++) begin
            apb(1'b1, FORR_OBS_ADDR[k], ~val(k, 0), rd, er);
            cmp1(er, 1'b0, "write to observation word");
            read_chk(FORR_OBS_ADDR[k], val(k, 0), 1'b0);
        end
        $display("test host write ignored done");
        read_chk(16'h12F4, 32'h0000_0000, 1'b1);
        read_chk(16'h1352, 32'h0000_0000, 1'b1);
        apb(1'b1, 16'h1370, 32'hFFFF_FFFF, rd, er);
        cmp1(er, 1'b1, "unmapped write");
        $display("test unmapped access done");
        i_pstrb <= 4'h0;
        apb(1'b1, FORR_ADDR_CTRL, 32'h0000_0001, rd, er);
        i_pstrb <= 4'hf;
        @(posedge i_ref_clk);
        cmp1(o_freeze, 1'b0, "freeze write without strobe");
        apb(1'b1, FORR_ADDR_CTRL, 32'h0000_0001, rd, er);
        @(posedge i_ref_clk);
        cmp1(o_freeze, 1'b1, "freeze set");
        read_chk(FORR_ADDR_CTRL, 32'h0000_0001, 1'b0);
        alg_all(32'h0F0F_0000);
        // visible values stay put while frozen
        read_chk(FORR_OBS_ADDR[0], val(0, 0), 1'b0);
        read_chk(FORR_ADDR_STAT, 32'h007F_017F, 1'b0);
        apb(1'b1, FORR_ADDR_CTRL, 32'h0000_0000, rd, er);
        repeat (2) @(posedge i_ref_clk);
        cmp1(o_freeze, 1'b0, "freeze cleared");
        read_chk(FORR_OBS_ADDR[6], val(6, 32'h0F0F_0000), 1'b0);
        read_chk(FORR_OBS_ADDR[3], val(3, 32'h0F0F_0000), 1'b0);
        $display("test freeze done");
        do_reset();
        for (int k = 0; k < FORR_NUM_OBS; k++) read_chk(FORR_OBS_ADDR[k], 32'h0000_0000, 1'b0);
        read_chk(FORR_ADDR_STAT, 32'h0000_0000, 1'b0);
        $display("test second reset done");
        results();
    end
endmodule
